// >>> logic/signal_loss_rx_config_regs.sv
// Receive-path configuration registers behind a two-wire serial slave, with
// signal-loss level selection and edge masking of the loss indicator.
// Assumes scl and sda_in are already synchronous to clk and the bus is slow
// against clk; sda is open drain, pulled high outside the block.
//
// Function
// - Select bit 1 applies register equalisation and bias; 0 uses built-in settings.
// - Equalisation code 00 gives some equalisation, 01 gives reduced equalisation.
// - Bias bit 1 adds extra input-stage bias current; 0 keeps default bias.
// - Level select 1 takes assert level from seven-bit field, 0 minimum, 7f maximum.
// - Level select 0 ignores the field and uses the 25 mV default level.
// - Falling-edge mask enable turns falling-edge masking on or off.
// - Six-bit falling mask time grows monotonically from under 10 us to over 2 ms.
// - Rising-edge mask enable turns rising-edge masking on or off.
// - Six-bit rising mask time grows monotonically from under 10 us to over 2 ms.
// - Read-only seven-bit field reports the assert level actually in use.
`timescale 1ns/100ps
module signal_loss_rx_config_regs #(
  parameter int unsigned MASK_BASE_CYCLES = signal_loss_pkg::MASK_BASE_CYC,
  parameter int unsigned MASK_STEP_CYCLES = signal_loss_pkg::MASK_STEP_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       raw_loss,
  output logic            signal_loss_indicator,
  output logic [1:0]      equalisation_code,
  output logic            input_bias_boost,
  output logic [6:0]      active_assert_level
);

  typedef enum logic [3:0] {
    IDLE, ADDR, ADDR_ACK, REG, REG_ACK, WDATA, WDATA_ACK, RDATA, RDATA_ACK
  } slave_state_type;

  // Bus slave state
  slave_state_type state_reg;
  slave_state_type state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic       sda_oe_reg;
  logic       sda_oe_next;
  logic       nack_reg;
  logic       nack_next;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic       wr_stb;
  logic [7:0] rd_data;

  // Register file state
  logic [7:0] rx_opt_reg;
  logic [7:0] rx_opt_next;
  logic [7:0] level_reg;
  logic [7:0] level_next;
  logic [7:0] fall_reg;
  logic [7:0] fall_next;
  logic [7:0] rise_reg;
  logic [7:0] rise_next;
  logic [1:0] eq_reg;
  logic [1:0] eq_next;
  logic       bias_reg;
  logic       bias_next;
  logic [6:0] active_reg;
  logic [6:0] active_next;
  logic       sda_out_reg;

  // Bus conditions seen from the sampled lines
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  always_comb begin
    scl_rise   = scl & ~scl_prev_reg;
    scl_fall   = ~scl & scl_prev_reg;
    start_cond = scl & scl_prev_reg & sda_prev_reg & ~sda_in;
    stop_cond  = scl & scl_prev_reg & ~sda_prev_reg & sda_in;
  end

  // Read data multiplexer; unmapped offsets read as zero
  always_comb begin
    unique case (ptr_reg)
      signal_loss_pkg::OFS_RX_OPT:     rd_data = rx_opt_reg;
      signal_loss_pkg::OFS_ASSERT_LVL: rd_data = level_reg;
      signal_loss_pkg::OFS_FALL_MASK:  rd_data = fall_reg;
      signal_loss_pkg::OFS_RISE_MASK:  rd_data = rise_reg;
      signal_loss_pkg::OFS_ACTIVE_LVL: rd_data = {1'b0, active_reg};
      default:                         rd_data = 8'h00;
    endcase
  end

  // Two-wire slave: address byte, register pointer, then data bytes
  always_comb begin
    state_next   = state_reg;
    shift_next   = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    ptr_next     = ptr_reg;
    sda_oe_next  = sda_oe_reg;
    nack_next    = nack_reg;
    wr_stb       = 1'b0;
    if (start_cond) begin
      state_next   = ADDR;
      bit_cnt_next = 4'h0;
      sda_oe_next  = 1'b0;
    end else if (stop_cond) begin
      state_next  = IDLE;
      sda_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        IDLE: begin
          sda_oe_next = 1'b0;
        end
        ADDR, REG, WDATA: begin
          if (scl_rise && bit_cnt_reg < 4'h8) begin
            shift_next   = {shift_reg[6:0], sda_in};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_next = 4'h0;
            sda_oe_next  = 1'b1;
            if (state_reg == ADDR) begin
              if (shift_reg[7:1] == signal_loss_pkg::DEVICE_ADDR) begin
                state_next = ADDR_ACK;
              end else begin
                state_next  = IDLE;
                sda_oe_next = 1'b0;
              end
            end else if (state_reg == REG) begin
              ptr_next   = shift_reg;
              state_next = REG_ACK;
            end else begin
              wr_stb     = 1'b1;
              state_next = WDATA_ACK;
            end
          end
        end
        ADDR_ACK: begin
          if (scl_fall) begin
            if (shift_reg[0]) begin
              shift_next  = rd_data;
              sda_oe_next = ~rd_data[7];
              state_next  = RDATA;
            end else begin
              sda_oe_next = 1'b0;
              state_next  = REG;
            end
          end
        end
        REG_ACK: begin
          if (scl_fall) begin
            sda_oe_next = 1'b0;
            state_next  = WDATA;
          end
        end
        WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_next = 1'b0;
            ptr_next    = ptr_reg + 8'h01;
            state_next  = WDATA;
          end
        end
        RDATA: begin
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_next = 4'h0;
            sda_oe_next  = 1'b0;
            state_next   = RDATA_ACK;
          end else if (scl_fall && bit_cnt_reg != 4'h0) begin
            shift_next  = {shift_reg[6:0], 1'b0};
            sda_oe_next = ~shift_reg[6];
          end
        end
        RDATA_ACK: begin
          if (scl_rise) begin
            nack_next = sda_in;
            if (!sda_in) begin
              ptr_next = ptr_reg + 8'h01; // Step early so the next byte is ready at the fall
            end
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_next = IDLE;
            end else begin
              state_next  = RDATA;
              shift_next  = rd_data;
              sda_oe_next = ~rd_data[7];
            end
          end
        end
        default: begin
          state_next = IDLE;
        end
      endcase
    end
    // Reload the next read byte once the pointer has moved on
    if (state_reg == RDATA_ACK && state_next == RDATA) begin
      shift_next = rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg    <= IDLE;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 4'h0;
      ptr_reg      <= 8'h00;
      sda_oe_reg   <= 1'b0;
      nack_reg     <= 1'b0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      sda_out_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      bit_cnt_reg  <= bit_cnt_next;
      ptr_reg      <= ptr_next;
      sda_oe_reg   <= sda_oe_next;
      nack_reg     <= nack_next;
      scl_prev_reg <= scl;
      sda_prev_reg <= sda_in;
      sda_out_reg  <= 1'b0;
    end
  end

  // Register writes and the settings handed to the analog path
  always_comb begin
    rx_opt_next = rx_opt_reg;
    level_next  = level_reg;
    fall_next   = fall_reg;
    rise_next   = rise_reg;
    if (wr_stb) begin
      unique case (ptr_reg)
        signal_loss_pkg::OFS_RX_OPT:     rx_opt_next = shift_reg & signal_loss_pkg::RX_OPT_MASK;
        signal_loss_pkg::OFS_ASSERT_LVL: level_next  = shift_reg;
        signal_loss_pkg::OFS_FALL_MASK:  fall_next   = shift_reg & 8'hbf;
        signal_loss_pkg::OFS_RISE_MASK:  rise_next   = shift_reg & 8'hbf;
        default:                         rx_opt_next = rx_opt_reg;
      endcase
    end
    if (rx_opt_reg[signal_loss_pkg::RX_OPT_SEL_BIT]) begin
      eq_next   = {rx_opt_reg[signal_loss_pkg::RX_OPT_EQ_HI],
                   rx_opt_reg[signal_loss_pkg::RX_OPT_EQ_LO]};
      bias_next = rx_opt_reg[signal_loss_pkg::RX_OPT_BIAS_BIT];
    end else begin
      eq_next   = signal_loss_pkg::DEFAULT_EQ_CODE;
      bias_next = signal_loss_pkg::DEFAULT_BIAS_BOOST;
    end
    if (level_reg[signal_loss_pkg::LVL_SEL_BIT]) begin
      active_next = level_reg[6:0];
    end else begin
      active_next = signal_loss_pkg::DEFAULT_LEVEL_CODE;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_opt_reg <= signal_loss_pkg::RST_RX_OPT;
      level_reg  <= signal_loss_pkg::RST_ASSERT_LVL;
      fall_reg   <= signal_loss_pkg::RST_FALL_MASK;
      rise_reg   <= signal_loss_pkg::RST_RISE_MASK;
      eq_reg     <= signal_loss_pkg::DEFAULT_EQ_CODE;
      bias_reg   <= signal_loss_pkg::DEFAULT_BIAS_BOOST;
      active_reg <= signal_loss_pkg::DEFAULT_LEVEL_CODE;
    end else begin
      rx_opt_reg <= rx_opt_next;
      level_reg  <= level_next;
      fall_reg   <= fall_next;
      rise_reg   <= rise_next;
      eq_reg     <= eq_next;
      bias_reg   <= bias_next;
      active_reg <= active_next;
    end
  end

  // Edge masking of the loss indicator
  loss_mask_if mask_bus ();

  assign mask_bus.fall_mask_enable = fall_reg[signal_loss_pkg::MASK_ENA_BIT];
  assign mask_bus.fall_mask_time   = fall_reg[signal_loss_pkg::MASK_TIME_MSB:0];
  assign mask_bus.rise_mask_enable = rise_reg[signal_loss_pkg::MASK_ENA_BIT];
  assign mask_bus.rise_mask_time   = rise_reg[signal_loss_pkg::MASK_TIME_MSB:0];
  assign mask_bus.raw_loss         = raw_loss;

  loss_edge_mask #(
    .BASE_CYC (MASK_BASE_CYCLES),
    .STEP_CYC (MASK_STEP_CYCLES)
  ) u_mask (
    .clk    (clk),
    .resetn (resetn),
    .mask   (mask_bus)
  );

  // Outputs, each from a flip-flop
  assign sda_out               = sda_out_reg;
  assign sda_oe                = sda_oe_reg;
  assign signal_loss_indicator = mask_bus.signal_loss_indicator;
  assign equalisation_code     = eq_reg;
  assign input_bias_boost      = bias_reg;
  assign active_assert_level   = active_reg;

endmodule

// >>> logic/signal_loss_pkg.sv
// Constants shared by the receive-path configuration block and its mask unit.
// Assumes a 100 MHz system clock; times are kept in ns and turned into cycles here.
package signal_loss_pkg;

  // Clock period
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Register offsets on the two-wire interface
  localparam logic [7:0] OFS_RX_OPT      = 8'h07;
  localparam logic [7:0] OFS_ASSERT_LVL  = 8'h0b;
  localparam logic [7:0] OFS_FALL_MASK   = 8'h0c;
  localparam logic [7:0] OFS_RISE_MASK   = 8'h0d;
  localparam logic [7:0] OFS_ACTIVE_LVL  = 8'h0f;

  // Field positions in the receiver optimisation register
  localparam int unsigned RX_OPT_SEL_BIT  = 7;
  localparam int unsigned RX_OPT_EQ_HI    = 3;
  localparam int unsigned RX_OPT_EQ_LO    = 2;
  localparam int unsigned RX_OPT_BIAS_BIT = 0;
  localparam logic [7:0]  RX_OPT_MASK     = 8'h8d;

  // Field positions in the level and mask registers
  localparam int unsigned LVL_SEL_BIT   = 7;
  localparam int unsigned MASK_ENA_BIT  = 7;
  localparam int unsigned MASK_TIME_MSB = 5;

  // Reset values
  localparam logic [7:0] RST_RX_OPT     = 8'h00;
  localparam logic [7:0] RST_ASSERT_LVL = 8'h00;
  localparam logic [7:0] RST_FALL_MASK  = 8'h00;
  localparam logic [7:0] RST_RISE_MASK  = 8'h00;

  // Built-in receiver settings used while software has not selected its own
  localparam logic [1:0] DEFAULT_EQ_CODE    = 2'h0;
  localparam logic       DEFAULT_BIAS_BOOST = 1'b0;

  // Code of the built-in 25 mV peak-to-peak assert level
  localparam logic [6:0] DEFAULT_LEVEL_CODE = 7'h10;

  // Two-wire address of the device, arbitrary value
  localparam logic [6:0] DEVICE_ADDR = 7'h2a;

  // Mask time: base plus code times step
  localparam int unsigned MASK_BASE_NS   = 5000;
  localparam int unsigned MASK_STEP_NS   = 40000;
  localparam int unsigned MASK_BASE_CYC  = MASK_BASE_NS / CLK_PERIOD_NS;
  localparam int unsigned MASK_STEP_CYC  = MASK_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned MASK_CNT_WIDTH = 24;

endpackage

// >>> logic/loss_mask_if.sv
// Carries the signal-loss mask settings and the indicator between the
// register block and the edge mask unit; both sit on the same clock.
`timescale 1ns/100ps
interface loss_mask_if;
  logic       fall_mask_enable;
  logic [5:0] fall_mask_time;
  logic       rise_mask_enable;
  logic [5:0] rise_mask_time;
  logic       raw_loss;
  logic       signal_loss_indicator;

  modport ctrl (output fall_mask_enable, fall_mask_time, rise_mask_enable,
                output rise_mask_time, raw_loss, input signal_loss_indicator);
  modport unit (input fall_mask_enable, fall_mask_time, rise_mask_enable,
                input rise_mask_time, raw_loss, output signal_loss_indicator);
endinterface

// >>> logic/loss_edge_mask.sv
// Holds off changes of the signal-loss indicator for a programmed time.
// Assumes the raw detector level is synchronous to clk.
`timescale 1ns/100ps
module loss_edge_mask #(
  parameter int unsigned BASE_CYC = signal_loss_pkg::MASK_BASE_CYC,
  parameter int unsigned STEP_CYC = signal_loss_pkg::MASK_STEP_CYC
) (
  input wire logic   clk,
  input wire logic   resetn,
  loss_mask_if.unit  mask
);

  localparam int unsigned W = signal_loss_pkg::MASK_CNT_WIDTH;

  logic         out_reg;
  logic         out_next;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] target;
  logic         rising;
  logic         enabled;

  // Mask length grows with the code, shortest at zero, longest at all ones
  always_comb begin
    rising  = mask.raw_loss & ~out_reg;
    enabled = rising ? mask.rise_mask_enable : mask.fall_mask_enable;
    if (rising) begin
      target = W'(BASE_CYC) + W'(mask.rise_mask_time) * W'(STEP_CYC);
    end else begin
      target = W'(BASE_CYC) + W'(mask.fall_mask_time) * W'(STEP_CYC);
    end
  end

  // Follow the raw level at once, or only once it has held for the mask time
  always_comb begin
    out_next = out_reg;
    cnt_next = '0;
    if (mask.raw_loss != out_reg) begin
      if (!enabled) begin
        out_next = mask.raw_loss;
      end else if (cnt_reg >= target - W'(1)) begin
        out_next = mask.raw_loss;
      end else begin
        cnt_next = cnt_reg + W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      out_reg <= out_next;
      cnt_reg <= cnt_next;
    end
  end

  assign mask.signal_loss_indicator = out_reg;

endmodule

// >>> tb/signal_loss_rx_config_regs_chk.sv
// Port checker for the receive-path configuration block.
// Assumes bind to the top module with its mask parameters handed on.
`timescale 1ns/100ps
module signal_loss_rx_config_regs_chk #(
  parameter int unsigned MASK_BASE_CYCLES = 2,
  parameter int unsigned MASK_STEP_CYCLES = 3
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       scl,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       raw_loss,
  input wire logic       signal_loss_indicator,
  input wire logic [1:0] equalisation_code,
  input wire logic       input_bias_boost,
  input wire logic [6:0] active_assert_level
);
  localparam int LAG_MAX = MASK_BASE_CYCLES + 63 * MASK_STEP_CYCLES + 4;
  logic [15:0] lag_reg;
  logic [15:0] lag_next;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Counts cycles the indicator disagrees with the raw detector
  always_comb begin
    lag_next = (raw_loss != signal_loss_indicator) ? lag_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk) begin
    lag_reg <= resetn ? lag_next : 16'h0000;
  end

  // Bus start, then eight clock cycles where the slave stays off the line
  sequence start_seen;
    scl && $past(scl) && $fell(sda_in);
  endsequence
  sequence line_quiet;
    !sda_oe [*8];
  endsequence

  reset_values_a: assert property (
    $rose(resetn) |-> equalisation_code == 2'h0 && !input_bias_boost && !signal_loss_indicator
      && active_assert_level == signal_loss_pkg::DEFAULT_LEVEL_CODE)
    else $error("outputs not at reset values");
  eq_on_write_a: assert property ($changed(equalisation_code) |-> !scl)
    else $error("equalisation changed outside a write");
  bias_on_write_a: assert property ($changed(input_bias_boost) |-> !scl)
    else $error("bias changed outside a write");
  level_on_write_a: assert property ($changed(active_assert_level) |-> !scl)
    else $error("assert level changed outside a write");
  ind_source_a: assert property (
    $changed(signal_loss_indicator) |-> signal_loss_indicator == $past(raw_loss))
    else $error("indicator moved against the detector");
  ind_lag_a: assert property (lag_reg <= 16'(LAG_MAX))
    else $error("indicator lags past the longest mask");
  oe_steady_a: assert property ($changed(sda_oe) |-> !scl)
    else $error("data drive changed while clock high");
  addr_quiet_a: assert property (start_seen |=> line_quiet)
    else $error("data driven during address phase");
  sda_drive_a: assert property (sda_out == 1'b0)
    else $error("data drive value not low");
endmodule

// >>> tb/bus_host.sv
// Host model on the two-wire bus: makes the clock and pulls data low.
// Assumes data has a pull-up and comes back as the wired level.
`timescale 1ns/100ps
module bus_host #(
  parameter int HALF = 6
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(negedge clk);
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start();
    sda_pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl = 1'b0;
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    sda_pull = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask
  // Eight data slots, MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack, output logic [8:0] rx);
    for (int i = 0; i < 9; i++) begin
      sda_pull = (i < 8) ? ~tx[7 - i] : ~ack;
      half();
      scl = 1'b1;
      half();
      rx = {rx[7:0], sda};
      scl = 1'b0;
    end
  endtask
endmodule

// >>> tb/test_signal_loss_rx_config_regs.sv
// Self-checking bench for the receive-path configuration block.
// Assumes the bus host model and the port checker are compiled alongside.
`timescale 1ns/100ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR %0t got %h expected %h", $time, (got), (exp)); end end
module test_signal_loss_rx_config_regs;
  localparam int BASE = 2;
  localparam int STEP = 3;
  logic       clk;
  logic       resetn;
  logic       scl;
  logic       sda_pull;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic       raw_loss;
  logic       signal_loss_indicator;
  logic [1:0] equalisation_code;
  logic       input_bias_boost;
  logic [6:0] active_assert_level;
  logic [8:0] rx;
  logic [7:0] v;
  logic [7:0] cor [6];
  int         n_errors;
  int         compares;
  integer     seed;

  // Wired data line with pull-up
  assign sda = (sda_oe | sda_pull) ? 1'b0 : 1'b1;

  signal_loss_rx_config_regs #(.MASK_BASE_CYCLES(BASE), .MASK_STEP_CYCLES(STEP))
    signal_loss_rx_config_regs_i (.clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .raw_loss(raw_loss),
    .signal_loss_indicator(signal_loss_indicator), .equalisation_code(equalisation_code),
    .input_bias_boost(input_bias_boost), .active_assert_level(active_assert_level));
  bus_host bus_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [6:0] lvl(input logic [7:0] x);
    return x[7] ? x[6:0] : signal_loss_pkg::DEFAULT_LEVEL_CODE;
  endfunction

  // Single-byte register write, address acknowledge checked
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    bus_host_i.start();
    bus_host_i.xfer({signal_loss_pkg::DEVICE_ADDR, 1'b0}, 1'b1, rx);
    `CHECK(rx[0], 1'b0)
    bus_host_i.xfer(ptr, 1'b1, rx);
    bus_host_i.xfer(d, 1'b1, rx);
    bus_host_i.stop();
  endtask
  // Single-byte register read through a repeated start
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    bus_host_i.start();
    bus_host_i.xfer({signal_loss_pkg::DEVICE_ADDR, 1'b0}, 1'b1, rx);
    bus_host_i.xfer(ptr, 1'b1, rx);
    bus_host_i.start();
    bus_host_i.xfer({signal_loss_pkg::DEVICE_ADDR, 1'b1}, 1'b1, rx);
    bus_host_i.xfer(8'hff, 1'b1, rx);
    bus_host_i.stop();
    `CHECK(rx[8:1], exp)
  endtask
  // Moves the detector and counts cycles until the indicator follows
  task automatic lag(input logic b, input logic [7:0] cfg);
    int n;
    int lo;
    n = 0;
    lo = cfg[7] ? BASE + int'(cfg[5:0]) * STEP : 1;
    raw_loss = b;
    while (signal_loss_indicator !== b && n < 400) begin
      @(negedge clk);
      n++;
    end
    `CHECK(n >= lo && n <= lo + (cfg[7] ? 3 : 1), 1'b1)
  endtask

  task automatic end_of_test();
    $display("Errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog against a hung bus or indicator
  initial begin
    #600000;
    n_errors++;
    end_of_test();
  end

  initial begin
    seed = 32'h8d5e3988;
    n_errors = 0;
    compares = 0;
    raw_loss = 1'b0;
    resetn = 1'b0;
    cor = '{8'h80, 8'h8d, 8'h0d, 8'hff, 8'h7f, 8'h85};
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    `CHECK(active_assert_level, signal_loss_pkg::DEFAULT_LEVEL_CODE)
    `CHECK(equalisation_code, 2'h0)
    rd(signal_loss_pkg::OFS_ACTIVE_LVL, 8'h10);
    rd(signal_loss_pkg::OFS_FALL_MASK, 8'h00);
    // Receiver and level settings: corners, then random
    for (int k = 0; k < 10; k++) begin
      v = (k < 6) ? cor[k] : 8'($random(seed));
      wr(signal_loss_pkg::OFS_RX_OPT, v);
      wr(signal_loss_pkg::OFS_ASSERT_LVL, v);
      `CHECK(equalisation_code, v[7] ? v[3:2] : 2'h0)
      `CHECK(input_bias_boost, v[7] & v[0])
      `CHECK(active_assert_level, lvl(v))
      rd(signal_loss_pkg::OFS_RX_OPT, v & signal_loss_pkg::RX_OPT_MASK);
      rd(signal_loss_pkg::OFS_ASSERT_LVL, v);
    end
    // Read-only level and an unmapped place
    wr(signal_loss_pkg::OFS_ACTIVE_LVL, ~v);
    rd(signal_loss_pkg::OFS_ACTIVE_LVL, {1'b0, lvl(v)});
    rd(8'h20, 8'h00);
    // Short detector pulse under a rising mask is swallowed
    wr(signal_loss_pkg::OFS_RISE_MASK, 8'h85);
    raw_loss = 1'b1;
    repeat (6) @(negedge clk);
    raw_loss = 1'b0;
    repeat (30) @(negedge clk);
    `CHECK(signal_loss_indicator, 1'b0)
    // Mask enable and time per direction: code corners, then random
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'h80 : (k == 1) ? 8'h81 : (k == 2) ? 8'hbf : 8'($random(seed));
      wr(signal_loss_pkg::OFS_RISE_MASK, v);
      wr(signal_loss_pkg::OFS_FALL_MASK, ~v);
      rd(signal_loss_pkg::OFS_RISE_MASK, v & 8'hbf);
      lag(1'b1, v);
      lag(1'b0, ~v);
    end
    end_of_test();
  end
endmodule

bind signal_loss_rx_config_regs signal_loss_rx_config_regs_chk #(
  .MASK_BASE_CYCLES(MASK_BASE_CYCLES), .MASK_STEP_CYCLES(MASK_STEP_CYCLES))
  signal_loss_rx_config_regs_chk_i (.clk(clk), .resetn(resetn), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .raw_loss(raw_loss),
  .signal_loss_indicator(signal_loss_indicator), .equalisation_code(equalisation_code),
  .input_bias_boost(input_bias_boost), .active_assert_level(active_assert_level));
